// ### rtl/ftbf_regs.vh
// Register map, field layout, reset values and timing constants of the field flag block
`ifndef FTBF_REGS_VH
`define FTBF_REGS_VH

`define FTBF_ADDR_THRESH      5'h06
`define FTBF_ADDR_DIR         5'h09
`define FTBF_ADDR_STATUS      5'h1b

`define FTBF_CMD_READ         3'h2
`define FTBF_CMD_WRITE        3'h4

`define FTBF_LOW_THR_HI       7
`define FTBF_LOW_THR_LO       5
`define FTBF_HIGH_THR_HI      4
`define FTBF_HIGH_THR_LO      2
`define FTBF_STAT_HIGH_BIT    7
`define FTBF_STAT_LOW_BIT     6
`define FTBF_DIR_BIT          7

`define FTBF_THRESH_RESET     8'h1c
`define FTBF_DIR_RESET        8'h00
`define FTBF_CFG_MASK         8'hfc
`define FTBF_DIR_MASK         8'h80

`define FTBF_FRAME_BITS       5'h10
`define FTBF_CLK_NS           100
`define FTBF_PWM_PERIOD_NS    20000
`define FTBF_NVM_WRITE_MS     20
`define FTBF_PWM_MIN_CYC      8'h14

`endif

// ### rtl/ftbf_top.v
// Field threshold flags, register access over the serial port, and angle PWM output
`timescale 1ns/10ps
//
// Overview of operation
// RQ1: The high flag goes to 1 when the field rises above the high threshold and clears only below its falling level.
// RQ2: The low flag goes to 1 when the field drops below the low threshold and clears only above its rising level.
// RQ3: Each 3-bit code selects a rising level of 26..126 mT and a falling level of 20..120 mT.
// RQ4: Both thresholds live as 3-bit fields in the threshold register, whose two lowest bits are unused.
// RQ5: The low threshold sits in bits 7 to 5 and the high threshold in bits 4 to 2.
// RQ6: Any pair of threshold codes is accepted unchanged, even a low code above the high code.
// RQ7: The status register shows the high flag in bit 7 and the low flag in bit 6.
// RQ8: Each flag is driven continuously on its own output pin.
// RQ9: The host reads the flags with command 010, address 11011 and eight zero bits.
// RQ10: The frame after a status read returns the status byte, flags in bits 7 and 6.
// RQ11: The PWM duty jumps between maximum and minimum at the zero angle, direction set by the rotation bit.
// RQ12: A register read is two 16-bit frames, the second carrying the register value.
// RQ13: A write frame is command 100, address and value MSB first, stored in memory and echoed next frame.
// RQ14: The host waits 20 ms after a write, otherwise the echo shows the previous content.
// RQ15: After reset the threshold register is loaded from storage before flags are evaluated.
`include "ftbf_regs.vh"

module ftbf_top #(
  parameter NVM_WRITE_CYCLES = `FTBF_NVM_WRITE_MS * 1000000 / `FTBF_CLK_NS
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       spi_sclk,
  input  wire       spi_cs_n,
  input  wire       spi_mosi,
  output wire       spi_miso_o,
  output wire       spi_miso_oe,
  input  wire [7:0] field_strength,
  input  wire [7:0] raw_angle,
  output wire       field_high_flag,
  output wire       field_low_flag,
  output wire       pwm_out
);

  localparam PWM_PERIOD_CYC = `FTBF_PWM_PERIOD_NS / `FTBF_CLK_NS;
  localparam ST_LOAD = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_PROG = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Threshold table
  function [7:0] rise_mt;
    input [2:0] code;
    begin
      case (code) // RQ3
        3'h0: rise_mt = 8'h1a;
        3'h1: rise_mt = 8'h29;
        3'h2: rise_mt = 8'h38;
        3'h3: rise_mt = 8'h46;
        3'h4: rise_mt = 8'h54;
        3'h5: rise_mt = 8'h62;
        3'h6: rise_mt = 8'h70;
        default: rise_mt = 8'h7e;
      endcase
    end
  endfunction

  function [7:0] fall_mt;
    input [2:0] code;
    begin
      fall_mt = rise_mt(code) - 8'h06; // RQ3
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg [2:0]  sclk_q;
  reg [2:0]  cs_q;
  reg [1:0]  mosi_q;
  reg [7:0]  field_m_q;
  reg [7:0]  field_q;
  reg [7:0]  angle_m_q;
  reg [7:0]  angle_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q    <= 3'h0;
      cs_q      <= 3'h7;
      mosi_q    <= 2'h0;
      field_m_q <= 8'h00;
      field_q   <= 8'h00;
      angle_m_q <= 8'h00;
      angle_q   <= 8'h00;
    end else begin
      sclk_q    <= {sclk_q[1:0], spi_sclk};
      cs_q      <= {cs_q[1:0], spi_cs_n};
      mosi_q    <= {mosi_q[0], spi_mosi};
      field_m_q <= field_strength;
      field_q   <= field_m_q;
      angle_m_q <= raw_angle;
      angle_q   <= angle_m_q;
    end
  end

  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire cs_fall   = ~cs_q[1] & cs_q[2];
  wire cs_rise   = cs_q[1] & ~cs_q[2];
  wire cs_act    = ~cs_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Storage, working registers and start-up load
  reg [7:0]  nvm_thr_q;
  reg [7:0]  nvm_dir_q;
  reg [7:0]  cfg_thr_q;
  reg [7:0]  cfg_dir_q;
  reg [1:0]  state_q;
  reg [17:0] prog_cnt_q;
  reg [4:0]  prog_addr_q;
  reg [7:0]  prog_data_q;
  reg        wr_req;
  reg [4:0]  wr_addr;
  reg [7:0]  wr_data;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvm_thr_q   <= `FTBF_THRESH_RESET;
      nvm_dir_q   <= `FTBF_DIR_RESET;
      cfg_thr_q   <= `FTBF_THRESH_RESET;
      cfg_dir_q   <= `FTBF_DIR_RESET;
      state_q     <= ST_LOAD;
      prog_cnt_q  <= 18'h0_0000;
      prog_addr_q <= 5'h00;
      prog_data_q <= 8'h00;
    end else begin
      case (state_q)
        ST_LOAD: begin
          cfg_thr_q <= nvm_thr_q; // RQ15
          cfg_dir_q <= nvm_dir_q;
          state_q   <= ST_RUN;
        end
        ST_RUN: begin
          if (wr_req) begin
            prog_addr_q <= wr_addr;
            prog_data_q <= wr_data; // RQ6
            prog_cnt_q  <= NVM_WRITE_CYCLES[17:0] - 18'h0_0001;
            state_q     <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (prog_cnt_q == 18'h0_0000) begin // RQ14
            if (prog_addr_q == `FTBF_ADDR_THRESH) begin
              nvm_thr_q <= prog_data_q & `FTBF_CFG_MASK; // RQ4
              cfg_thr_q <= prog_data_q & `FTBF_CFG_MASK;
            end else if (prog_addr_q == `FTBF_ADDR_DIR) begin
              nvm_dir_q <= prog_data_q & `FTBF_DIR_MASK;
              cfg_dir_q <= prog_data_q & `FTBF_DIR_MASK;
            end
            state_q <= ST_RUN;
          end else begin
            prog_cnt_q <= prog_cnt_q - 18'h0_0001;
          end
        end
        default: state_q <= ST_LOAD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag comparators with hysteresis
  wire [2:0] low_thr  = cfg_thr_q[`FTBF_LOW_THR_HI:`FTBF_LOW_THR_LO];   // RQ5
  wire [2:0] high_thr = cfg_thr_q[`FTBF_HIGH_THR_HI:`FTBF_HIGH_THR_LO]; // RQ5
  reg        high_q;
  reg        low_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_q <= 1'b0;
      low_q  <= 1'b0;
    end else if (state_q != ST_LOAD) begin // RQ15
      if (field_q > rise_mt(high_thr))
        high_q <= 1'b1; // RQ1
      else if (field_q < fall_mt(high_thr))
        high_q <= 1'b0; // RQ1
      if (field_q < fall_mt(low_thr))
        low_q <= 1'b1; // RQ2
      else if (field_q > rise_mt(low_thr))
        low_q <= 1'b0; // RQ2
    end
  end

  assign field_high_flag = high_q; // RQ8
  assign field_low_flag  = low_q;  // RQ8

  wire [7:0] status_byte = {high_q, low_q, 6'h00}; // RQ7

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg [4:0]  bit_cnt_q;
  reg        pend_q;
  reg [4:0]  pend_addr_q;
  reg [7:0]  reg_rd;

  always @* begin
    case (pend_addr_q)
      `FTBF_ADDR_THRESH: reg_rd = nvm_thr_q;
      `FTBF_ADDR_DIR:    reg_rd = nvm_dir_q;
      `FTBF_ADDR_STATUS: reg_rd = status_byte; // RQ10
      default:           reg_rd = 8'h00;
    endcase
  end

  wire       frame_done = cs_rise && (bit_cnt_q == `FTBF_FRAME_BITS);
  wire [2:0] rx_cmd     = rx_q[15:13];

  always @* begin
    wr_req  = frame_done && (rx_cmd == `FTBF_CMD_WRITE) && (state_q == ST_RUN); // RQ13
    wr_addr = rx_q[12:8];
    wr_data = rx_q[7:0];
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_q        <= 16'h0000;
      tx_q        <= 16'h0000;
      bit_cnt_q   <= 5'h00;
      pend_q      <= 1'b0;
      pend_addr_q <= 5'h00;
    end else begin
      if (cs_fall) begin
        bit_cnt_q <= 5'h00;
        pend_q    <= 1'b0;
        tx_q      <= pend_q ? {reg_rd, 8'h00} : {angle_q, 8'h00}; // RQ12
      end else if (cs_act && sclk_rise && bit_cnt_q != ~5'h00) begin
        // Count saturates at 31 so that an over-long frame is refused at cs rise
        rx_q      <= {rx_q[14:0], mosi_q[1]};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end else if (cs_act && sclk_fall) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
      if (frame_done && (rx_cmd == `FTBF_CMD_READ || rx_cmd == `FTBF_CMD_WRITE)) begin
        pend_q      <= 1'b1; // RQ12
        pend_addr_q <= rx_q[12:8];
      end
    end
  end

  assign spi_miso_o  = tx_q[15];
  assign spi_miso_oe = cs_act;

  ////////////////////////////////////////////////////////////////////////////
  // Angle PWM, 10 % to 90 % duty over a 20 us period
  reg  [7:0] pwm_cnt_q;
  reg        pwm_q;
  wire [7:0] ang_dir = cfg_dir_q[`FTBF_DIR_BIT] ? (8'h00 - angle_q) : angle_q; // RQ11
  wire [10:0] ang_x5 = {3'h0, ang_dir} * 11'd5;
  wire [7:0] on_cyc  = `FTBF_PWM_MIN_CYC + ang_x5[10:3];

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_cnt_q <= 8'h00;
      pwm_q     <= 1'b0;
    end else begin
      if (pwm_cnt_q == PWM_PERIOD_CYC[7:0] - 8'h01)
        pwm_cnt_q <= 8'h00;
      else
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
      pwm_q <= (pwm_cnt_q < on_cyc); // RQ11
    end
  end

  assign pwm_out = pwm_q;

endmodule

// ### dv/ftbf_assertions.sv
// Port checks for the field flag block
`timescale 1ns/10ps
module ftbf_assertions (
  input wire       clk,
  input wire       sys_rst,
  input wire       spi_sclk,
  input wire       spi_cs_n,
  input wire       spi_mosi,
  input wire       spi_miso_o,
  input wire       spi_miso_oe,
  input wire [7:0] field_strength,
  input wire [7:0] raw_angle,
  input wire       field_high_flag,
  input wire       field_low_flag,
  input wire       pwm_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_oe_frame: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
    else $error("miso enabled outside a frame");
  chk_oe_active: assert property (!spi_cs_n [*6] |-> spi_miso_oe)
    else $error("miso not enabled in a frame");
  chk_miso_hold: assert property (spi_sclk [*3] |=> $stable(spi_miso_o))
    else $error("miso moved while sclk high");
  chk_high_floor: assert property ((field_strength < 8'h14) [*8] |=> !field_high_flag)
    else $error("high flag set below every level");
  chk_low_ceil: assert property ((field_strength > 8'h7e) [*8] |=> !field_low_flag)
    else $error("low flag set above every level");
  chk_high_rise: assert property ($rose(field_high_flag) |-> field_strength > 8'h19)
    else $error("high flag rose at low field");
  chk_low_rise: assert property ($rose(field_low_flag) |-> field_strength < 8'h78)
    else $error("low flag rose at high field");
  chk_pwm_min: assert property ($rose(pwm_out) |-> pwm_out [*8])
    else $error("pwm pulse too short");
  cover property ($rose(field_high_flag));
  cover property ($rose(field_low_flag));
  cover property ($fell(spi_miso_oe));
endmodule
bind ftbf_top ftbf_assertions u_chk (.clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso_o, .spi_miso_oe,
  .field_strength, .raw_angle, .field_high_flag, .field_low_flag, .pwm_out);

// ### dv/ftbf_host.sv
// Serial port master standing in for the host processor
`timescale 1ns/10ps
module ftbf_host (
  input  wire  clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input  wire  miso
);
  initial begin
    sclk = 0;
    cs_n = 1;
    mosi = 0;
  end
  // Mode 0 frame of 16 bits, MSB first, clock idle low, half period of 4 system clocks
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk);
    #2 cs_n = 0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      repeat (4) @(posedge clk);
      #2 sclk = 1;
      rx[i] = miso;
      repeat (4) @(posedge clk);
      #2 sclk = 0;
    end
    repeat (4) @(posedge clk);
    #2 cs_n = 1;
    mosi = ~mosi;
    repeat (12) @(posedge clk);
  endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the field flag block
`timescale 1ns/10ps
`include "ftbf_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t got %h", $time, a); end end
module tb;
  logic        clk = 0;
  logic        sys_rst = 1;
  localparam int NVM_CYC = 20;
  logic [7:0]  fs = 0;
  logic [7:0]  ang = 8'h5a;
  logic [15:0] rx;
  logic [7:0]  rs [8] = '{8'h1a, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7e};
  wire         sclk, cs_n, mosi, miso, oe, hi, lo, pwm;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  ftbf_top #(.NVM_WRITE_CYCLES(NVM_CYC)) u_ftbf_top (.clk(clk), .sys_rst(sys_rst), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso), .spi_miso_oe(oe), .field_strength(fs),
    .raw_angle(ang), .field_high_flag(hi), .field_low_flag(lo), .pwm_out(pwm));
  ftbf_host u_ftbf_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  ////////////////////////////////////////////////////////////////
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    u_ftbf_host.xfer({`FTBF_CMD_READ, a, 8'h00}, rx);
    u_ftbf_host.xfer(16'h0000, rx);
    v = rx[15:8];
  endtask
  // Early skips the storage wait, so the echo must still show the old content
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input bit early, output logic [7:0] v);
    u_ftbf_host.xfer({`FTBF_CMD_WRITE, a, d}, rx);
    if (!early) repeat (NVM_CYC) @(posedge clk);
    u_ftbf_host.xfer(16'h0000, rx);
    v = rx[15:8];
  endtask
  // Counts the cycles of one whole high phase of the PWM output
  task automatic pw(input logic [7:0] a, input int e);
    int n;
    @(posedge clk);
    #2 ang = a;
    repeat (250) @(posedge clk);
    @(posedge pwm);
    n = 0;
    while (pwm === 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n, e)
  endtask
  task automatic fl(input logic [7:0] f, input logic [1:0] e);
    @(posedge clk);
    #2 fs = f;
    repeat (12) @(posedge clk);
    `CHK({hi, lo}, e)
  endtask
  task automatic t_reset;
    logic [7:0] v;
    rd(`FTBF_ADDR_THRESH, v);
    `CHK(v, 8'h1c)
    fl(8'h00, 2'b01);
    rd(`FTBF_ADDR_STATUS, v);
    `CHK(v, 8'h40)
  endtask
  task automatic t_codes;
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      wr(`FTBF_ADDR_THRESH, {3'(c), 3'(c), 2'b11}, 1'b0, v);
      `CHK(v, {3'(c), 3'(c), 2'b00})
      fl(rs[c] - 8'h07, 2'b01);
      fl(rs[c] - 8'h01, 2'b01);
      fl(rs[c] + 8'h01, 2'b10);
      fl(rs[c] - 8'h05, 2'b10);
      fl(rs[c] - 8'h07, 2'b01);
    end
  endtask
  task automatic t_combo;
    logic [7:0] v;
    wr(`FTBF_ADDR_THRESH, 8'he1, 1'b1, v);
    `CHK(v, 8'hfc)
    rd(`FTBF_ADDR_THRESH, v);
    `CHK(v, 8'he0)
    fl(8'hc8, 2'b10);
    fl(8'h20, 2'b11);
    rd(`FTBF_ADDR_STATUS, v);
    `CHK(v, 8'hc0)
    rd(5'h03, v);
    `CHK(v, 8'h00)
  endtask
  // Top of the scale is 9/10 of the period less one angle step
  task automatic t_pwm;
    logic [7:0] v;
    pw(8'h00, `FTBF_PWM_MIN_CYC);
    pw(8'hff, 8'hb3);
    wr(`FTBF_ADDR_DIR, 8'h80, 1'b0, v);
    `CHK(v, 8'h80)
    pw(8'hff, `FTBF_PWM_MIN_CYC);
    pw(8'h01, 8'hb3);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 15000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #2 sys_rst = 0;
    repeat (4) @(posedge clk);
    t_reset;
    t_codes;
    t_combo;
    t_pwm;
    end_sim;
  end
endmodule
